// File: spim_cfg.svh
// constants for the serial peripheral core
// How it works
// - transmit data lives only in the shifter; received bytes go to a read buffer
// - finished byte copies to read buffer; software must read before next byte
// - each byte shifted out is matched by a byte sampled in
// - unselected slave releases its serial data output
// - polarity picks idle level; phase picks one of two formats
// - phase one lets select stay low across bytes
// - phase zero shift clock is select OR serial clock
// - serial outputs drive only when direction bit set; inputs always inputs
// - master presents each data bit half a clock before sampling edge
// - one byte exchanged over eight serial clock cycles
// - three-bit rate field sets clock rate only in master mode
// - master with select as input flags mode fault when select goes low
// - select direction bit set makes it an output, no mode fault
// - mode fault clears master select and the four direction bits; irq request
// - data write during transfer sets collision flag and is discarded
// - collisions detected in master and slave modes
// - master starts on data write, ends when done flag sets
// - phase zero slave transfer spans select low; done flag on eighth cycle
// - phase one slave transfer starts at first active edge, ends at done flag
// - lsb-first option reverses bit order
// - master divides clock by 2,4,16,32,8,16,64,128 per rate field
// - master serial clock idles at polarity level
// - done and collision flags clear by status read then data access
// - mode fault clears by status read then control write
`ifndef SPIM_CFG_SVH
`define SPIM_CFG_SVH
`define SPIM_CTL_IRQ_EN 7
`define SPIM_CTL_SYS_EN 6
`define SPIM_CTL_MASTER 4
`define SPIM_CTL_CLOCK_IDLE_POLARITY 3
`define SPIM_CTL_CLOCK_PHASE_SELECT 2
`define SPIM_CTL_RESET 8'h04
`define SPIM_DIR_MISO 2
`define SPIM_DIR_MOSI 3
`define SPIM_DIR_SCK 4
`define SPIM_DIR_SEL 5
`define SPIM_BITS 4'h8
`endif

// File: spim_clkdiv.sv
// master serial clock divider producing half-period ticks
`timescale 1ns/1ps
module spim_clkdiv (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic run,
    input wire logic [2:0] rate,
    output logic tick
);
    logic [6:0] cnt_reg;
    logic [6:0] half;

    function automatic logic [6:0] half_of(input logic [2:0] r);
        unique case (r)
            3'h0: half_of = 7'h01;
            3'h1: half_of = 7'h02;
            3'h2: half_of = 7'h08;
            3'h3: half_of = 7'h10;
            3'h4: half_of = 7'h04;
            3'h5: half_of = 7'h08;
            3'h6: half_of = 7'h20;
            3'h7: half_of = 7'h40;
        endcase
    endfunction : half_of

    assign half = half_of(rate);
    assign tick = run && (cnt_reg == half - 7'h01);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= 7'h00;
        end else if (ce) begin
            if (!run || tick) begin
                cnt_reg <= 7'h00;
            end else begin
                cnt_reg <= cnt_reg + 7'h01;
            end
        end
    end
endmodule : spim_clkdiv

// File: spim_core.sv
// serial peripheral core, master or slave, with cpu-side strobes
`timescale 1ns/1ps
`include "spim_cfg.svh"
module spim_core (
    input wire logic CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic CE_IN,
    input wire logic CTRL_WR_IN,
    input wire logic [7:0] CTRL_DATA_IN,
    input wire logic LSB_FIRST_IN,
    input wire logic RATE_HI_IN,
    input wire logic CPU_IRQ_MASK_IN,
    input wire logic DIR_WR_IN,
    input wire logic [3:0] DIR_DATA_IN,
    input wire logic STATUS_RD_IN,
    input wire logic DATA_RD_IN,
    input wire logic DATA_WR_IN,
    input wire logic [7:0] DATA_WR_VAL_IN,
    input wire logic MISO_IN,
    input wire logic MOSI_IN,
    input wire logic SCK_IN,
    input wire logic SEL_N_IN,
    output logic MISO_OUT,
    output logic MISO_OE_OUT,
    output logic MOSI_OUT,
    output logic MOSI_OE_OUT,
    output logic SCK_OUT,
    output logic SCK_OE_OUT,
    output logic [7:0] CTRL_OUT,
    output logic [3:0] DIR_OUT,
    output logic [7:0] STATUS_OUT,
    output logic [7:0] READ_DATA_OUT,
    output logic BUSY_OUT,
    output logic IRQ_OUT
);
    spim_pkg::spim_acc_t acc;
    spim_pkg::spim_edge_t sedge;
    spim_pkg::spim_state_t state_reg;
    logic [7:0] serial_control_reg;
    logic [3:0] port_d_direction_reg;
    logic [7:0] shift_reg;
    logic [7:0] serial_data_reg;
    logic [3:0] bit_cnt_reg;
    logic transfer_done_flag_reg;
    logic write_collision_flag_reg;
    logic mode_fault_flag_reg;
    logic done_armed_reg;
    logic mode_fault_flag_armed_reg;
    logic sck_reg;
    logic phase_reg;
    logic [2:0] miso_s_reg;
    logic [2:0] mosi_s_reg;
    logic [2:0] sck_s_reg;
    logic [2:0] sel_s_reg;
    logic enabled;
    logic master;
    logic clock_idle_polarity;
    logic clock_phase_select;
    logic sel_n;
    logic shift_clk;
    logic shift_clk_d;
    logic tick;
    logic run;
    logic busy;
    logic mode_fault;
    logic load_ok;
    logic byte_done;
    logic in_bit;
    logic out_bit;
    logic sel_is_input;
    logic [7:0] rx_reg;
    logic [1:0] samp_pipe_reg;
    logic [1:0] done_pipe_reg;
    logic last_smp;
    logic cap;
    logic tx_shift;

    // one received bit into a byte, either order
    function automatic logic [7:0] shift_in(input logic [7:0] b, input logic nb,
                                            input logic lsb);
        shift_in = lsb ? {nb, b[7:1]} : {b[6:0], nb};
    endfunction : shift_in

    assign acc = '{rd_status: STATUS_RD_IN, rd_data: DATA_RD_IN,
                   wr_data: DATA_WR_IN, wr_ctrl: CTRL_WR_IN};
    assign enabled = serial_control_reg[`SPIM_CTL_SYS_EN];
    assign master = serial_control_reg[`SPIM_CTL_MASTER];
    assign clock_idle_polarity = serial_control_reg[`SPIM_CTL_CLOCK_IDLE_POLARITY];
    assign clock_phase_select = serial_control_reg[`SPIM_CTL_CLOCK_PHASE_SELECT];

    // pins pass two flops; bit 2 holds the previous synced value for edges
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            miso_s_reg <= 3'h0;
            mosi_s_reg <= 3'h0;
            sck_s_reg <= 3'h0;
            sel_s_reg <= 3'h7;
        end else if (CE_IN) begin
            miso_s_reg <= {miso_s_reg[1:0], MISO_IN};
            mosi_s_reg <= {mosi_s_reg[1:0], MOSI_IN};
            sck_s_reg <= {sck_s_reg[1:0], SCK_IN};
            sel_s_reg <= {sel_s_reg[1:0], SEL_N_IN};
        end
    end

    // select stays an input only with its direction bit clear
    assign sel_is_input = !port_d_direction_reg[`SPIM_DIR_SEL - 2];
    assign sel_n = sel_is_input ? sel_s_reg[1] : 1'b1;

    // phase zero shift clock ORed with select; polarity normalised
    assign shift_clk = ((sck_s_reg[1] ^ clock_idle_polarity) | (!clock_phase_select & sel_s_reg[1]));
    assign shift_clk_d = ((sck_s_reg[2] ^ clock_idle_polarity) | (!clock_phase_select & sel_s_reg[2]));

    // rate field only used by the master divider
    assign run = enabled && master && (state_reg == spim_pkg::ST_RUN);
    spim_clkdiv u_div (
        .clk(CLK_IN),
        .rst_n(RESET_N_IN),
        .ce(CE_IN),
        .run(run),
        .rate({RATE_HI_IN, serial_control_reg[1:0]}),
        .tick(tick)
    );

    // slave edges come from the synced clock; master edges from its own ticks
    always_comb begin
        sedge = '{drive: 1'b0, sample: 1'b0};
        if (master) begin
            // phase one drives on the leading edge, phase zero samples there
            sedge.sample = tick && (phase_reg == clock_phase_select);
            sedge.drive = tick && (phase_reg != clock_phase_select);
        end else if (enabled && !sel_s_reg[1] && state_reg != spim_pkg::ST_HOLD) begin
            // phase one slave keeps shifting with select held low
            sedge.sample = (shift_clk ^ clock_phase_select) && !(shift_clk_d ^ clock_phase_select) && shift_clk != shift_clk_d;
            sedge.drive = !(shift_clk ^ clock_phase_select) && (shift_clk_d ^ clock_phase_select) && shift_clk != shift_clk_d;
        end
    end

    // master with select as input faults when it goes low
    assign mode_fault = enabled && master && sel_is_input && !sel_n;

    // transfer-in-progress window
    // master stays busy until the delayed last bit lands
    assign busy = (state_reg != spim_pkg::ST_IDLE) || (|done_pipe_reg)
                  || (!master && enabled && !clock_phase_select && !sel_s_reg[1]);
    // write while busy collides; blocked until status read
    assign load_ok = acc.wr_data && !busy
                     && !((transfer_done_flag_reg || write_collision_flag_reg)
                          && !done_armed_reg);
    assign last_smp = sedge.sample && (bit_cnt_reg == `SPIM_BITS - 4'h1);
    // master input lags two clocks behind its own edges through the pin flops
    assign byte_done = done_pipe_reg[1] || (!master && last_smp);
    assign cap = samp_pipe_reg[1] || (!master && sedge.sample);
    // first phase-one drive edge shows the bit already loaded, no shift
    assign tx_shift = sedge.drive && (state_reg == spim_pkg::ST_RUN)
                      && (bit_cnt_reg != 4'h0);
    assign in_bit = master ? miso_s_reg[1] : mosi_s_reg[1];
    assign out_bit = LSB_FIRST_IN ? shift_reg[0] : shift_reg[7];

    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            state_reg <= spim_pkg::ST_IDLE;
            bit_cnt_reg <= 4'h0;
            phase_reg <= 1'b0;
        end else if (CE_IN) begin
            unique case (state_reg)
                spim_pkg::ST_IDLE: begin
                    bit_cnt_reg <= 4'h0;
                    phase_reg <= 1'b0;
                    if (master && load_ok && enabled) begin
                        state_reg <= spim_pkg::ST_RUN;
                    end else if (!master && sedge.sample) begin
                        // phase one slave begins on first active edge
                        state_reg <= spim_pkg::ST_RUN;
                        bit_cnt_reg <= 4'h1;
                    end
                end
                spim_pkg::ST_RUN: begin
                    if (tick) begin
                        phase_reg <= !phase_reg;
                    end
                    if (sedge.sample) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    if (last_smp) begin
                        state_reg <= (!master && !clock_phase_select) ? spim_pkg::ST_HOLD
                                                        : spim_pkg::ST_IDLE;
                    end
                    if (mode_fault || !enabled) begin
                        state_reg <= spim_pkg::ST_IDLE;
                    end
                end
                spim_pkg::ST_HOLD: begin
                    // phase zero slave busy until select rises
                    if (sel_s_reg[1] || !enabled) begin
                        state_reg <= spim_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // transmit shifter: load, then next bit on each running drive edge after the first sample
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            shift_reg <= 8'h00;
        end else if (CE_IN) begin
            if (load_ok) begin
                shift_reg <= DATA_WR_VAL_IN;
            end else if (tx_shift) begin
                shift_reg <= LSB_FIRST_IN ? {1'b0, shift_reg[7:1]}
                                          : {shift_reg[6:0], 1'b0};
            end
        end
    end

    // receive side collects the sampled bits
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            rx_reg <= 8'h00;
        end else if (CE_IN && cap) begin
            rx_reg <= shift_in(rx_reg, in_bit, LSB_FIRST_IN);
        end
    end

    // sample and end marks delayed to match the two pin flops
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            samp_pipe_reg <= 2'h0;
            done_pipe_reg <= 2'h0;
        end else if (CE_IN) begin
            samp_pipe_reg <= {samp_pipe_reg[0], master && sedge.sample};
            done_pipe_reg <= {done_pipe_reg[0], master && last_smp};
        end
    end

    // completed byte copied to read buffer
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            serial_data_reg <= 8'h00;
        end else if (CE_IN && byte_done) begin
            serial_data_reg <= shift_in(rx_reg, in_bit, LSB_FIRST_IN);
        end
    end

    // master clock idles at polarity, toggles only while running
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            sck_reg <= 1'b0;
        end else if (CE_IN) begin
            if (!run) begin
                sck_reg <= clock_idle_polarity;
            end else if (tick && !(last_smp && clock_phase_select)) begin
                sck_reg <= !sck_reg;
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            transfer_done_flag_reg <= 1'b0;
            write_collision_flag_reg <= 1'b0;
            mode_fault_flag_reg <= 1'b0;
            done_armed_reg <= 1'b0;
            mode_fault_flag_armed_reg <= 1'b0;
        end else if (CE_IN) begin
            if (acc.rd_status && (transfer_done_flag_reg || write_collision_flag_reg)) begin
                done_armed_reg <= 1'b1;
            end else if (acc.rd_data || acc.wr_data) begin
                done_armed_reg <= 1'b0;
            end
            if (acc.rd_status && mode_fault_flag_reg) begin
                mode_fault_flag_armed_reg <= 1'b1;
            end else if (acc.wr_ctrl) begin
                mode_fault_flag_armed_reg <= 1'b0;
            end
            if (byte_done) begin
                transfer_done_flag_reg <= 1'b1;
            end else if (done_armed_reg && (acc.rd_data || acc.wr_data)) begin
                transfer_done_flag_reg <= 1'b0;
            end
            if (acc.wr_data && busy) begin
                write_collision_flag_reg <= 1'b1;
            end else if (done_armed_reg && (acc.rd_data || acc.wr_data)) begin
                write_collision_flag_reg <= 1'b0;
            end
            if (mode_fault) begin
                mode_fault_flag_reg <= 1'b1;
            end else if (mode_fault_flag_armed_reg && acc.wr_ctrl) begin
                mode_fault_flag_reg <= 1'b0;
            end
        end
    end

    // mode fault clears master select and direction bits
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            serial_control_reg <= `SPIM_CTL_RESET;
            port_d_direction_reg <= 4'h0;
        end else if (CE_IN) begin
            if (acc.wr_ctrl) begin
                serial_control_reg <= CTRL_DATA_IN;
            end
            if (DIR_WR_IN) begin
                port_d_direction_reg <= DIR_DATA_IN;
            end
            if (mode_fault) begin
                serial_control_reg[`SPIM_CTL_MASTER] <= 1'b0;
                port_d_direction_reg <= 4'h0;
            end
        end
    end

    // outputs drive only with their direction bit set; slave release
    assign MOSI_OUT = out_bit;
    assign MOSI_OE_OUT = enabled && master && port_d_direction_reg[`SPIM_DIR_MOSI - 2];
    assign SCK_OUT = sck_reg;
    assign SCK_OE_OUT = enabled && master && port_d_direction_reg[`SPIM_DIR_SCK - 2];
    assign MISO_OUT = out_bit;
    assign MISO_OE_OUT = enabled && !master && !sel_s_reg[1]
                         && port_d_direction_reg[`SPIM_DIR_MISO - 2];

    assign CTRL_OUT = serial_control_reg;
    assign DIR_OUT = port_d_direction_reg;
    assign STATUS_OUT = {transfer_done_flag_reg, write_collision_flag_reg, 1'b0,
                         mode_fault_flag_reg, 4'h0};
    assign READ_DATA_OUT = serial_data_reg;
    assign BUSY_OUT = busy;
    // request gated by enable and cpu mask
    assign IRQ_OUT = serial_control_reg[`SPIM_CTL_IRQ_EN] && !CPU_IRQ_MASK_IN
                     && (transfer_done_flag_reg || mode_fault_flag_reg);
endmodule : spim_core

// File: spim_core_checker.sv
// port assertions for the serial core
`timescale 1ns/1ps
module spim_core_checker (
    input wire logic CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic CPU_IRQ_MASK_IN,
    input wire logic DATA_WR_IN,
    input wire logic SEL_N_IN,
    input wire logic MISO_OE_OUT,
    input wire logic MOSI_OE_OUT,
    input wire logic SCK_OUT,
    input wire logic [7:0] CTRL_OUT,
    input wire logic [3:0] DIR_OUT,
    input wire logic [7:0] STATUS_OUT,
    input wire logic BUSY_OUT,
    input wire logic IRQ_OUT
);
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RESET_N_IN);
    // settled master with no transfer running
    sequence s_idle;
        $stable(CTRL_OUT) && CTRL_OUT[4] && !BUSY_OUT;
    endsequence
    sequence s_busy_wr;
        $past(DATA_WR_IN) && $past(BUSY_OUT);
    endsequence
    a_sck_idle_lvl: assert property (s_idle [*3] |-> SCK_OUT == CTRL_OUT[3])
        else $error("sck off idle level");
    a_miso_release: assert property (SEL_N_IN [*4] |-> !MISO_OE_OUT)
        else $error("miso driven while deselected");
    // one cycle of slack in case the enable is registered
    a_mosi_dir_gate: assert property (MOSI_OE_OUT |-> DIR_OUT[1] || $past(DIR_OUT[1]))
        else $error("mosi driven without direction bit");
    a_busy_start: assert property ($rose(BUSY_OUT) && CTRL_OUT[4] |-> $past(DATA_WR_IN))
        else $error("master busy without data write");
    a_write_collision_flag_cause: assert property ($rose(STATUS_OUT[6]) |-> s_busy_wr)
        else $error("collision flag without busy write");
    a_mode_fault_flag_cause: assert property ($rose(STATUS_OUT[4]) |->
        $past(CTRL_OUT[4]) && !$past(DIR_OUT[3]))
        else $error("mode fault outside master input select");
    a_mode_fault_flag_release: assert property ($rose(STATUS_OUT[4]) |->
        ##[0:2] (!CTRL_OUT[4] && DIR_OUT == 4'h0))
        else $error("mode fault left drivers on");
    a_irq_level: assert property (IRQ_OUT == (CTRL_OUT[7] && !CPU_IRQ_MASK_IN
        && (STATUS_OUT[7] || STATUS_OUT[4])))
        else $error("irq mismatch");
endmodule : spim_core_checker

// File: spim_core_tb.sv
// self-checking bench for the serial core
`timescale 1ns/1ps
bind spim_core spim_core_checker i_chk (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN),
    .CPU_IRQ_MASK_IN(CPU_IRQ_MASK_IN), .DATA_WR_IN(DATA_WR_IN), .SEL_N_IN(SEL_N_IN),
    .MISO_OE_OUT(MISO_OE_OUT), .MOSI_OE_OUT(MOSI_OE_OUT), .SCK_OUT(SCK_OUT),
    .CTRL_OUT(CTRL_OUT), .DIR_OUT(DIR_OUT), .STATUS_OUT(STATUS_OUT),
    .BUSY_OUT(BUSY_OUT), .IRQ_OUT(IRQ_OUT));
module spim_core_tb;
    localparam logic [4:0] K_CTRL = 5'h10;
    localparam logic [4:0] K_DIR = 5'h08;
    localparam logic [4:0] K_STAT = 5'h04;
    localparam logic [4:0] K_RD = 5'h02;
    localparam logic [4:0] K_WR = 5'h01;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] stb = 5'h00;
    logic lsb_first_select = 1'b0;
    logic rhi = 1'b0;
    logic imask = 1'b0;
    logic sel_n = 1'b1;
    logic [7:0] val = 8'h00;
    logic [7:0] ptx = 8'h00;
    logic [31:0] seed = 32'h7CAA80D9;
    logic [31:0] v;
    wire logic miso, mosi, sck, miso_oe, mosi_oe, busy, irq;
    wire logic [7:0] ctrl, stat, rdat, prx;
    wire logic [3:0] dir;
    int error_cnt = 0;
    int samples_checked = 0;
    int edges = 0;
    int bcnt = 0;
    spim_core i_dut (.CLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(1'b1),
        .CTRL_WR_IN(stb[4]), .CTRL_DATA_IN(val), .LSB_FIRST_IN(lsb_first_select), .RATE_HI_IN(rhi),
        .CPU_IRQ_MASK_IN(imask), .DIR_WR_IN(stb[3]), .DIR_DATA_IN(val[3:0]),
        .STATUS_RD_IN(stb[2]), .DATA_RD_IN(stb[1]), .DATA_WR_IN(stb[0]),
        .DATA_WR_VAL_IN(val), .MISO_IN(miso), .MOSI_IN(1'b0), .SCK_IN(1'b0),
        .SEL_N_IN(sel_n), .MISO_OUT(), .MISO_OE_OUT(miso_oe), .MOSI_OUT(mosi),
        .MOSI_OE_OUT(mosi_oe), .SCK_OUT(sck), .SCK_OE_OUT(), .CTRL_OUT(ctrl),
        .DIR_OUT(dir), .STATUS_OUT(stat), .READ_DATA_OUT(rdat), .BUSY_OUT(busy),
        .IRQ_OUT(irq));
    spim_peer i_peer (.sck_in(sck), .sel_n_in(sel_n), .mosi_in(mosi), .clock_idle_polarity_in(ctrl[3]),
        .clock_phase_select_in(ctrl[2]), .lsb_first_select_in(lsb_first_select), .tx_in(ptx), .miso_out(miso), .rx_out(prx));
    always #10 clk = ~clk;
    always @(sck) edges++;
    always @(posedge clk) if (busy === 1'b1) bcnt++;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic int divf(input logic [2:0] r);
        int t [8] = '{2, 4, 16, 32, 8, 16, 64, 128};
        return t[r];
    endfunction : divf
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic acc(input logic [4:0] k, input logic [7:0] d);
        @(negedge clk);
        stb = k;
        val = d;
        @(negedge clk);
        stb = 5'h00;
    endtask : acc
    task automatic xfer(input logic [1:0] m, input logic [2:0] r, input logic l,
        input logic [7:0] tx, input logic [7:0] pt, input logic col);
        int d;
        d = divf(r);
        lsb_first_select = l;
        rhi = r[2];
        ptx = pt;
        acc(K_CTRL, {4'h5, m, r[1:0]});
        acc(K_DIR, 8'h0E);
        sel_n = 1'b0;
        edges = 0;
        bcnt = 0;
        acc(K_WR, tx);
        if (col) acc(K_WR, ~tx);
        for (int n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge clk);
        repeat (2) @(negedge clk);
        sel_n = 1'b1;
        chk(stat, col ? 8'hC0 : 8'h80);
        chk(rdat, pt);
        chk(prx, tx);
        chk(edges[7:0], 8'h10);
        chk({7'h0, bcnt >= 8 * d - d / 2 && bcnt <= 8 * d + 8}, 8'h01);
        // stays idle: flag still unread
        acc(K_WR, pt);
        @(negedge clk);
        chk({7'h0, busy}, 8'h00);
        acc(K_STAT, 8'h00);
        acc(K_RD, 8'h00);
        chk(stat, 8'h00);
    endtask : xfer
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        test_done();
    end
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        chk(ctrl, 8'h04);
        chk({4'h0, dir}, 8'h00);
        chk(stat, 8'h00);
        chk({6'h0, miso_oe, mosi_oe}, 8'h00);
        for (int i = 0; i < 8; i++) begin
            xfer(i[1:0], i[2] ? 3'h7 : 3'h0, i[2], 8'h81, 8'h7E, 1'b0);
        end
        for (int i = 0; i < 8; i++) begin
            v = rnd();
            xfer(v[1:0], i[2:0], v[2], v[15:8], v[23:16], v[3]);
        end
        acc(K_CTRL, 8'hD0);
        acc(K_DIR, 8'h06);
        sel_n = 1'b0;
        repeat (5) @(negedge clk);
        sel_n = 1'b1;
        chk(stat, 8'h10);
        chk(ctrl, 8'hC0);
        chk({4'h0, dir}, 8'h00);
        chk({7'h0, irq}, 8'h01);
        imask = 1'b1;
        #1;
        chk({7'h0, irq}, 8'h00);
        acc(K_CTRL, 8'hC0);
        chk(stat, 8'h10);
        acc(K_STAT, 8'h00);
        acc(K_CTRL, 8'h40);
        chk(stat, 8'h00);
        acc(K_DIR, 8'h01);
        chk({7'h0, miso_oe}, 8'h00);
        sel_n = 1'b0;
        repeat (4) @(negedge clk);
        chk({7'h0, miso_oe}, 8'h01);
        acc(K_WR, 8'h5A);
        chk(stat, 8'h40);
        sel_n = 1'b1;
        repeat (4) @(negedge clk);
        chk({7'h0, miso_oe}, 8'h00);
        test_done();
    end
endmodule : spim_core_tb

// File: spim_peer.sv
// behavioural serial slave facing the core in master mode
`timescale 1ns/1ps
module spim_peer (
    input wire logic sck_in,
    input wire logic sel_n_in,
    input wire logic mosi_in,
    input wire logic clock_idle_polarity_in,
    input wire logic clock_phase_select_in,
    input wire logic lsb_first_select_in,
    input wire logic [7:0] tx_in,
    output logic miso_out,
    output logic [7:0] rx_out
);
    int cnt_reg = 8;
    initial miso_out = 1'b0;
    initial rx_out = 8'h00;
    function automatic int pos(input int i);
        return lsb_first_select_in ? i : 7 - i;
    endfunction : pos
    always @(negedge sel_n_in) begin
        cnt_reg = 0;
        if (!clock_phase_select_in) miso_out = tx_in[pos(0)];
    end
    // inverted so a stale bit cannot pass
    always @(posedge sel_n_in) miso_out = ~miso_out;
    // phase zero samples on leading edge
    always @(sck_in) begin
        if (!sel_n_in && cnt_reg < 8) begin
            if ((sck_in != clock_idle_polarity_in) ^ clock_phase_select_in) begin
                rx_out[pos(cnt_reg)] = mosi_in;
                cnt_reg++;
            end else begin
                miso_out = tx_in[pos(cnt_reg)];
            end
        end
    end
endmodule : spim_peer

// File: spim_pkg.sv
// types for the serial peripheral core
package spim_pkg;
    typedef struct packed {
        logic rd_status;
        logic rd_data;
        logic wr_data;
        logic wr_ctrl;
    } spim_acc_t;
    typedef struct packed {
        logic drive;
        logic sample;
    } spim_edge_t;
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HOLD} spim_state_t;
endpackage : spim_pkg
